/* File: fbm_pkg.sv */
package fbm_pkg;

	// ****************************************
	// register map (byte offsets, wishbone)
	// ****************************************
	localparam logic [5:0] OFS_CMD0 = 6'h00;
	localparam logic [5:0] OFS_CTRL = 6'h2c;
	localparam logic [5:0] OFS_STAT = 6'h30;
	localparam logic [5:0] OFS_OWN  = 6'h34;

	localparam int CTRL_GO_BIT   = 0;
	localparam int STAT_BUSY_BIT = 8;

	// ****************************************
	// command block layout (word index)
	// ****************************************
	localparam int CMD_WORDS = 11;
	localparam logic [3:0] W_LEN   = 4'h0;
	localparam logic [3:0] W_MODE  = 4'h1;
	localparam logic [3:0] W_STMT  = 4'h2;
	localparam logic [3:0] W_STAD  = 4'h3;
	localparam logic [3:0] W_CODE  = 4'h6;
	localparam logic [3:0] W_RMT   = 4'h7;
	localparam logic [3:0] W_RADR  = 4'h8;
	localparam logic [3:0] W_RSIZE = 4'h9;
	localparam logic [3:0] W_SLAVE = 4'ha;

	localparam logic [15:0] CMD_DEV_STATUS = 16'h0001;
	localparam logic [15:0] CMD_MST_STATUS = 16'h0002;

	// ****************************************
	// response memory types
	// ****************************************
	localparam logic [15:0] MT_REG   = 16'h0008;
	localparam logic [15:0] MT_AIN   = 16'h000a;
	localparam logic [15:0] MT_AOUT  = 16'h000c;
	localparam logic [15:0] MT_DIN   = 16'h0010;
	localparam logic [15:0] MT_DOUT  = 16'h0012;
	localparam logic [15:0] MT_TEMP  = 16'h0014;
	localparam logic [15:0] MT_INTL  = 16'h0016;
	localparam logic [15:0] STEP_WORD = 16'h0001;
	localparam logic [15:0] STEP_BYTE = 16'h0002;

	// ****************************************
	// command status values
	// ****************************************
	localparam logic [7:0] CS_PENDING = 8'h00;
	localparam logic [7:0] CS_DONE    = 8'h01;
	localparam logic [7:0] CS_BADCMD  = 8'h03;
	localparam logic [7:0] CS_BADDATA = 8'h04;
	localparam logic [7:0] CS_NOMEM   = 8'h07;

	// ****************************************
	// reply sizing
	// ****************************************
	localparam logic [15:0] REPLY_WORDS     = 16'h0002;
	localparam logic [15:0] RESP_FULL_WORDS = 16'h0009;
	localparam int DEF_SLAVES = 126;

	// ****************************************
	// slave link condition codes
	// ****************************************
	localparam logic [7:0] SLC_OK         = 8'h00;
	localparam logic [7:0] SLC_CFG_FAIL   = 8'h01;
	localparam logic [7:0] SLC_ID_DIFF    = 8'h02;
	localparam logic [7:0] SLC_UPD_FRAME  = 8'h03;
	localparam logic [7:0] SLC_DIAG_FRAME = 8'h04;
	localparam logic [7:0] SLC_CFG_DS1    = 8'h05;
	localparam logic [7:0] SLC_CFG_DS2    = 8'h06;
	localparam logic [7:0] SLC_RD_DS1     = 8'h07;
	localparam logic [7:0] SLC_RD_DS2     = 8'h08;
	localparam logic [7:0] SLC_ADDR_DIFF  = 8'h09;
	localparam logic [7:0] SLC_IO_TMO     = 8'h0a;
	localparam logic [7:0] SLC_WDOG_OFF   = 8'h0b;

	localparam logic [7:0] EXT_NONE       = 8'h00;
	localparam logic [7:0] EXT_CFG_LAST   = 8'h09;
	localparam logic [7:0] EXT_UPD_CFG    = 8'h0a;
	localparam logic [7:0] EXT_UPD_ONLINE = 8'h0b;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_CHECK   = 3'b001,
		ST_WR_ECHO = 3'b010,
		ST_WR_COND = 3'b011
	} fbm_state_t;

	function automatic logic mt_valid(input logic [15:0] mt);
		mt_valid = (mt == MT_REG) || (mt == MT_AIN) || (mt == MT_AOUT) ||
			(mt == MT_DIN) || (mt == MT_DOUT) || (mt == MT_TEMP) ||
			(mt == MT_INTL);
	endfunction

	function automatic logic [15:0] mt_step(input logic [15:0] mt);
		if (mt >= MT_DIN)
			mt_step = STEP_BYTE;
		else
			mt_step = STEP_WORD;
	endfunction

endpackage

/* File: fbm_stat_if.sv */
`timescale 1ns/1ns
interface fbm_stat_if;
	logic [7:0]  cond;
	logic [7:0]  ext;
	logic [15:0] word;

	modport enc
	(
		input  cond,
		input  ext,
		output word
	);
	modport user
	(
		output cond,
		output ext,
		input  word
	);
endinterface

/* File: fbm_stat_enc.sv */
`timescale 1ns/1ns
module fbm_stat_enc
(
	// condition in, reply word out
	fbm_stat_if.enc st
);

	// ****************************************
	// extended byte only beside codes 01 and 03
	// ****************************************
	always_comb
	begin
		st.word = {fbm_pkg::EXT_NONE, st.cond};
		if (st.cond == fbm_pkg::SLC_CFG_FAIL &&
			st.ext <= fbm_pkg::EXT_CFG_LAST)
			st.word[15:8] = st.ext;
		else if (st.cond == fbm_pkg::SLC_UPD_FRAME &&
			(st.ext == fbm_pkg::EXT_UPD_CFG ||
			st.ext == fbm_pkg::EXT_UPD_ONLINE))
			st.word[15:8] = st.ext;
	end

endmodule

/* File: fbm_cmd.sv */
// How it works
// - first reply word echoes command number
// - second word: condition low, extended high
// - codes 00 ok, 01 config, 02 identity
// - codes 03, 04 frame delivery failures
// - codes 05..08 diagnostic status byte errors
// - codes 09 address, 0a timeout, 0b watchdog
// - extended byte meaningful only for 01, 03
// - config extended 00..04 no response details
// - config extended 05,06,07,09 invalid response
// - extended 08 non-empty config check answer
// - update extended 0a configuring, 0b online
// - command number 2 runs master status
// - seven response memory types accepted
// - start offset zero based, units set by memory type
// - only two reply words are written
// - own or absent slave gives status 4
// - area too small gives 07, ignored
`timescale 1ns/1ns
module fbm_cmd
#(
	parameter int SLAVES = fbm_pkg::DEF_SLAVES
)
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// slave condition updates from the bus engine
	input  wire logic        slv_upd_i,
	input  wire logic        slv_drop_i,
	input  wire logic [6:0]  slv_num_i,
	input  wire logic [7:0]  slv_cond_i,
	input  wire logic [7:0]  slv_ext_i,
	// master condition word
	input  wire logic [15:0] mst_cond_i,
	// reply writes into requester memory
	output logic             mem_wr_o,
	output logic      [15:0] mem_type_o,
	output logic      [15:0] mem_addr_o,
	output logic      [15:0] mem_data_o,
	input  wire logic        mem_rdy_i,
	// activity
	output logic             busy_o
);

	if (SLAVES < 1 || SLAVES > 128)
		$error("fbm_cmd: SLAVES must be 1 to 128");

	typedef struct packed {
		fbm_pkg::fbm_state_t             st;
		logic                            busy;
		logic [7:0]                      status;
		logic [6:0]                      own;
		logic [fbm_pkg::CMD_WORDS-1:0][15:0] cmd;
		logic [SLAVES-1:0][15:0]         cond;
		logic [SLAVES-1:0]               present;
		logic [15:0]                     word2;
		logic [15:0]                     waddr;
		logic [15:0]                     wdata;
		logic                            ack;
		logic [31:0]                     rdat;
	} fbm_regs_t;

	fbm_regs_t s;
	fbm_regs_t next_s;

	// ****************************************
	// condition encoder
	// ****************************************
	fbm_stat_if stat_if ();

	assign stat_if.cond = slv_cond_i;
	assign stat_if.ext  = slv_ext_i;

	fbm_stat_enc u_enc
	(
		.st (stat_if.enc)
	);

	logic [15:0] code;
	logic [15:0] slave;
	logic        sel_dev;
	logic        in_cmd;
	logic [3:0]  widx;

	assign code    = s.cmd[fbm_pkg::W_CODE];
	assign slave   = s.cmd[fbm_pkg::W_SLAVE];
	assign sel_dev = (code == fbm_pkg::CMD_DEV_STATUS);
	assign widx    = wb_adr_i[5:2];
	assign in_cmd  = (wb_adr_i < fbm_pkg::OFS_CTRL);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_s = s;
		next_s.ack = 1'b0;

		// status table kept current, update wins over drop
		if (slv_drop_i && int'(slv_num_i) < SLAVES)
			next_s.present[slv_num_i] = 1'b0;
		if (slv_upd_i && int'(slv_num_i) < SLAVES)
		begin
			next_s.present[slv_num_i] = 1'b1;
			next_s.cond[slv_num_i] = stat_if.word;
		end

		// bus access
		if (wb_cyc_i && wb_stb_i && !s.ack)
		begin
			next_s.ack = 1'b1;
			next_s.rdat = 32'h0000_0000;
			if (in_cmd && wb_adr_i[1:0] == 2'h0)
			begin
				next_s.rdat[15:0] = s.cmd[widx];
				if (wb_we_i && !s.busy && wb_sel_i[0])
					next_s.cmd[widx][7:0] = wb_dat_i[7:0];
				if (wb_we_i && !s.busy && wb_sel_i[1])
					next_s.cmd[widx][15:8] = wb_dat_i[15:8];
			end
			else if (wb_adr_i == fbm_pkg::OFS_CTRL)
			begin
				if (wb_we_i && wb_sel_i[0] &&
					wb_dat_i[fbm_pkg::CTRL_GO_BIT] && !s.busy)
				begin
					next_s.busy = 1'b1;
					next_s.status = fbm_pkg::CS_PENDING;
					next_s.st = fbm_pkg::ST_CHECK;
				end
			end
			else if (wb_adr_i == fbm_pkg::OFS_STAT)
			begin
				next_s.rdat[7:0] = s.status;
				next_s.rdat[fbm_pkg::STAT_BUSY_BIT] = s.busy;
			end
			else if (wb_adr_i == fbm_pkg::OFS_OWN)
			begin
				next_s.rdat[6:0] = s.own;
				if (wb_we_i && wb_sel_i[0] && !s.busy)
					next_s.own = wb_dat_i[6:0];
			end
		end

		// command engine
		case (s.st)
			fbm_pkg::ST_IDLE:
			begin
				next_s.busy = next_s.busy;
			end
			fbm_pkg::ST_CHECK:
			begin
				next_s.st = fbm_pkg::ST_IDLE;
				next_s.busy = 1'b0;
				if (code != fbm_pkg::CMD_DEV_STATUS &&
					code != fbm_pkg::CMD_MST_STATUS)
					next_s.status = fbm_pkg::CS_BADCMD;
				else if (!fbm_pkg::mt_valid(s.cmd[fbm_pkg::W_RMT]))
					next_s.status = fbm_pkg::CS_BADDATA;
				else if (sel_dev && (slave >= 16'(SLAVES) ||
					slave[6:0] == s.own || !s.present[slave[6:0]]))
					next_s.status = fbm_pkg::CS_BADDATA;
				else if (s.cmd[fbm_pkg::W_RSIZE] < fbm_pkg::REPLY_WORDS)
					next_s.status = fbm_pkg::CS_NOMEM;
				else
				begin
					next_s.busy = 1'b1;
					next_s.st = fbm_pkg::ST_WR_ECHO;
					next_s.waddr = s.cmd[fbm_pkg::W_RADR];
					next_s.wdata = code;
					if (sel_dev)
						next_s.word2 = s.cond[slave[6:0]];
					else
						next_s.word2 = mst_cond_i;
				end
			end
			fbm_pkg::ST_WR_ECHO:
			begin
				if (mem_rdy_i)
				begin
					next_s.waddr = s.waddr +
						fbm_pkg::mt_step(s.cmd[fbm_pkg::W_RMT]);
					next_s.wdata = s.word2;
					next_s.st = fbm_pkg::ST_WR_COND;
				end
			end
			fbm_pkg::ST_WR_COND:
			begin
				if (mem_rdy_i)
				begin
					next_s.status = fbm_pkg::CS_DONE;
					next_s.busy = 1'b0;
					next_s.st = fbm_pkg::ST_IDLE;
				end
			end
			default:
			begin
				next_s.st = fbm_pkg::ST_IDLE;
				next_s.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wb_ack_o   = s.ack;
	assign wb_dat_o   = s.rdat;
	assign busy_o     = s.busy;
	assign mem_wr_o   = (s.st == fbm_pkg::ST_WR_ECHO) ||
		(s.st == fbm_pkg::ST_WR_COND);
	assign mem_type_o = s.cmd[fbm_pkg::W_RMT];
	assign mem_addr_o = s.waddr;
	assign mem_data_o = s.wdata;

	// ****************************************
	// checks
	// ****************************************
	logic [3:0] hs_cnt;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || s.st == fbm_pkg::ST_CHECK)
			hs_cnt <= 4'h0;
		else if (mem_wr_o && mem_rdy_i)
			hs_cnt <= hs_cnt + 4'h1;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_echo_word: assert property (
		s.st == fbm_pkg::ST_WR_ECHO |-> mem_data_o == code)
		else $error("echo word wrong");

	chk_cond_low: assert property (
		stat_if.word[7:0] == slv_cond_i)
		else $error("condition byte wrong");

	chk_ext_masked: assert property (
		slv_cond_i != fbm_pkg::SLC_CFG_FAIL &&
		slv_cond_i != fbm_pkg::SLC_UPD_FRAME |-> stat_if.word[15:8] == 8'h00)
		else $error("extended byte not cleared");

	chk_ext_cfg: assert property (
		slv_cond_i == fbm_pkg::SLC_CFG_FAIL &&
		slv_ext_i <= fbm_pkg::EXT_CFG_LAST |-> stat_if.word[15:8] == slv_ext_i)
		else $error("config extended byte wrong");

	chk_ext_upd: assert property (
		slv_cond_i == fbm_pkg::SLC_UPD_FRAME &&
		slv_ext_i == fbm_pkg::EXT_UPD_ONLINE |-> stat_if.word[15:8] == slv_ext_i)
		else $error("update extended byte wrong");

	chk_two_words: assert property (
		hs_cnt <= 4'h2)
		else $error("more than two reply words");

	chk_absent_slave: assert property (
		s.st == fbm_pkg::ST_CHECK && sel_dev &&
		fbm_pkg::mt_valid(s.cmd[fbm_pkg::W_RMT]) && slave >= 16'(SLAVES)
		|=> s.status == fbm_pkg::CS_BADDATA && !mem_wr_o && !s.busy)
		else $error("absent slave not refused");

	chk_small_area: assert property (
		s.st == fbm_pkg::ST_CHECK && code == fbm_pkg::CMD_MST_STATUS &&
		fbm_pkg::mt_valid(s.cmd[fbm_pkg::W_RMT]) &&
		s.cmd[fbm_pkg::W_RSIZE] < fbm_pkg::REPLY_WORDS
		|=> s.status == fbm_pkg::CS_NOMEM ##1 !mem_wr_o)
		else $error("small area not refused");

	chk_addr_step: assert property (
		s.st == fbm_pkg::ST_WR_ECHO && mem_rdy_i |=> mem_addr_o ==
		16'($past(mem_addr_o) + fbm_pkg::mt_step($past(mem_type_o))))
		else $error("reply address step wrong");

	chk_done_status: assert property (
		s.st == fbm_pkg::ST_WR_COND && mem_rdy_i
		|=> s.status == fbm_pkg::CS_DONE && !mem_wr_o)
		else $error("completion status missing");

endmodule

/* File: fbm_host_mem.sv */
`timescale 1ns/1ns
module fbm_host_mem
(
	// clock, reset, log clear, stall select
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        clr_i,
	input  wire logic        slow_i,
	// reply write port
	input  wire logic        mem_wr_i,
	input  wire logic [15:0] mem_type_i,
	input  wire logic [15:0] mem_addr_i,
	input  wire logic [15:0] mem_data_i,
	output logic             mem_rdy_o,
	// write log
	output logic      [3:0]  cnt_o,
	output logic      [15:0] t_o,
	output logic      [15:0] a0_o,
	output logic      [15:0] d0_o,
	output logic      [15:0] a1_o,
	output logic      [15:0] d1_o
);
	// ****************************************
	// controller memory with optional stall
	// ****************************************
	logic tick;

	// reply area is reserved whole, nothing else lives there
	assign mem_rdy_o = mem_wr_i & (~slow_i | tick);

	always_ff @(posedge clk_i)
	begin
		tick <= rst_i ? 1'b0 : ~tick;
		if (rst_i | clr_i)
			cnt_o <= 4'h0;
		else if (mem_wr_i & mem_rdy_o)
		begin
			cnt_o <= cnt_o + 4'h1;
			t_o   <= mem_type_i;
			if (cnt_o == 4'h0)
			begin
				a0_o <= mem_addr_i;
				d0_o <= mem_data_i;
			end
			else
			begin
				a1_o <= mem_addr_i;
				d1_o <= mem_data_i;
			end
		end
	end
endmodule

/* File: fbm_cmd_tb.sv */
`timescale 1ns/1ns
module fbm_cmd_tb;
	// ****************************************
	// signals
	// ****************************************
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic        upd = 0, drop = 0, slow = 0, clr = 0;
	logic [5:0]  adr = '0;
	logic [31:0] dat = '0, wb_dat_o, r;
	logic        wb_ack_o, mem_wr, mem_rdy, busy;
	logic [6:0]  num = '0;
	logic [7:0]  cond = '0, ext = '0, xe;
	logic [15:0] mst = 16'h2b00, mt, ma, md, t, a0, d0, a1, d1;
	logic [3:0]  cnt;
	int          error_cnt = 0, num_checks = 0, cyc_cnt = 0, i;
	logic [15:0] mts [7] = '{fbm_pkg::MT_REG, fbm_pkg::MT_AIN,
		fbm_pkg::MT_AOUT, fbm_pkg::MT_DIN, fbm_pkg::MT_DOUT,
		fbm_pkg::MT_TEMP, fbm_pkg::MT_INTL};

	fbm_cmd DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.slv_upd_i(upd), .slv_drop_i(drop), .slv_num_i(num),
		.slv_cond_i(cond), .slv_ext_i(ext), .mst_cond_i(mst),
		.mem_wr_o(mem_wr), .mem_type_o(mt), .mem_addr_o(ma),
		.mem_data_o(md), .mem_rdy_i(mem_rdy), .busy_o(busy));

	fbm_host_mem host (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
		.slow_i(slow), .mem_wr_i(mem_wr), .mem_type_i(mt),
		.mem_addr_i(ma), .mem_data_i(md), .mem_rdy_o(mem_rdy),
		.cnt_o(cnt), .t_o(t), .a0_o(a0), .d0_o(d0), .a1_o(a1), .d1_o(d1));

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	// ****************************************
	// tasks
	// ****************************************
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input string nm, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk_i);
	endtask

	task slv(input logic u, input logic dr, input logic [6:0] n,
		input logic [7:0] c, input logic [7:0] x);
		upd  <= u;
		drop <= dr;
		num  <= n;
		cond <= c;
		ext  <= x;
		@(posedge clk_i);
		upd  <= 1'b0;
		drop <= 1'b0;
		@(posedge clk_i);
	endtask

	task cmd(input logic [15:0] code, m, st, sz, sl, stat, nw, w2);
		wb(1'b1, 6'h00, 32'h4);
		wb(1'b1, 6'h04, 32'h0);
		wb(1'b1, 6'h08, 32'h8);
		wb(1'b1, 6'h0c, 32'h9);
		wb(1'b1, 6'h18, {16'h0, code});
		wb(1'b1, 6'h1c, {16'h0, m});
		wb(1'b1, 6'h20, {16'h0, st});
		wb(1'b1, 6'h24, {16'h0, sz});
		wb(1'b1, 6'h28, {16'h0, sl});
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		wb(1'b1, 6'h2c, 32'h1);
		r = 32'h100;
		while (r[8] !== 1'b0)
		begin
			wb(1'b0, 6'h30, 32'h0);
		end
		check("status", {8'h0, r[7:0]}, stat);
		check("busy", {15'h0, busy}, 16'h0);
		check("writes", {12'h0, cnt}, nw);
		if (nw == 16'h2)
		begin
			check("type", t, m);
			check("addr0", a0, st);
			check("echo", d0, code);
			check("addr1", a1, st + ((m >= 16'h10) ? 16'h2 : 16'h1));
			check("word2", d1, w2);
		end
	endtask

	// ****************************************
	// timeout
	// ****************************************
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 8000)
		begin
			error_cnt++;
			tally_and_finish;
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 6'h30, 32'h0);
		check("rst status", r[15:0], 16'h0);
		wb(1'b0, 6'h3c, 32'h0);
		check("unmapped", r[15:0], 16'h0);
		wb(1'b1, 6'h34, 32'h5);
		wb(1'b0, 6'h34, 32'h0);
		check("own", r[15:0], 16'h5);
		slv(1'b1, 1'b0, 7'd5, 8'h0, 8'h0);
		slv(1'b1, 1'b0, 7'd3, 8'h0, 8'h0);
		slv(1'b0, 1'b1, 7'd3, 8'h0, 8'h0);
		cmd(1, mts[0], 10, 9, 5, 4, 0, 0);
		cmd(1, mts[0], 10, 9, 3, 4, 0, 0);
		cmd(1, mts[0], 10, 9, 7, 4, 0, 0);
		cmd(1, mts[0], 10, 9, 126, 4, 0, 0);
		for (i = 0; i < 12; i++)
		begin
			xe = (i == 1) ? 8'h08 : (i == 3) ? 8'h0a : 8'h05;
			slv(1'b1, 1'b0, 7'd1, i[7:0], xe);
			slow <= i[0];
			cmd(1, mts[i % 7], 16'h20 + i[15:0], 9, 1, 1, 2,
				{(i == 1 || i == 3) ? xe : 8'h0, i[7:0]});
		end
		for (i = 0; i < 12; i++)
		begin
			xe = (i < 10) ? 8'h01 : 8'h03;
			slv(1'b1, 1'b0, 7'd2, xe, i[7:0]);
			cmd(1, mts[i % 7], 16'h40, 2, 2, 1, 2, {i[7:0], xe});
		end
		cmd(1, mts[0], 0, 1, 1, 7, 0, 0);
		cmd(2, mts[0], 0, 1, 0, 7, 0, 0);
		cmd(2, mts[4], 4, 9, 0, 1, 2, 16'h2b00);
		cmd(3, mts[0], 4, 9, 1, 3, 0, 0);
		cmd(1, 16'h9, 4, 9, 1, 4, 0, 0);
		tally_and_finish;
	end
endmodule
